/* File: hw/emsb_strobe.sv */
// Registered strobe, byte-lane mask and I/O bank chip-select outputs.
// Assumes the core presents one access request per cycle, synchronous to CLOCK.
//
// Functional notes
// - Write strobe goes low only for a DRAM write command, else high.
// - Mask high on a write lane makes memory ignore that byte.
// - Mask high on a read lane stops memory driving that byte.
// - Four mask bits, bit n governs data bits 8n+7 down to 8n.
// - Three active-low chip selects for external memory-mapped I/O.
// - Each bank spans 16KB; its window asserts only its own select.
// - The asserted select identifies the targeted bank.
`timescale 1ns/1ps
`include "emsb_params.svh"
module emsb_strobe #(
  parameter logic [`EMSB_ADDR_W-1:0] BANK0_BASE = `EMSB_BANK0_BASE,
  parameter logic [`EMSB_ADDR_W-1:0] BANK1_BASE = `EMSB_BANK1_BASE,
  parameter logic [`EMSB_ADDR_W-1:0] BANK2_BASE = `EMSB_BANK2_BASE
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire emsb_pkg::emsb_req_t REQ,
  output logic DRAM_WRITE_STROBE_N,
  output logic [`EMSB_LANES-1:0] DRAM_BYTE_LANE_MASK,
  output logic [`EMSB_BANKS-1:0] IO_BANK_SELECT_N
);
  import emsb_pkg::*;

  // Bank window hit: upper address bits above the 16KB span match the base
  function automatic logic bank_hit(input logic [`EMSB_ADDR_W-1:0] a,
                                    input logic [`EMSB_ADDR_W-1:0] base);
    bank_hit = (a[`EMSB_ADDR_W-1:`EMSB_BANK_SPAN_W] == base[`EMSB_ADDR_W-1:`EMSB_BANK_SPAN_W]);
  endfunction

  wire logic is_io = (REQ.op == EMSB_OP_IO);
  wire logic is_wr = (REQ.op == EMSB_OP_DRAM_WR);
  wire logic is_rd = (REQ.op == EMSB_OP_DRAM_RD);
  wire logic hit0 = is_io && bank_hit(REQ.addr, BANK0_BASE);
  wire logic hit1 = is_io && !hit0 && bank_hit(REQ.addr, BANK1_BASE);
  wire logic hit2 = is_io && !hit0 && !hit1 && bank_hit(REQ.addr, BANK2_BASE);
  // Priority chain keeps selects one-hot even if windows overlap by misconfiguration
  wire logic [`EMSB_BANKS-1:0] next_sel_n = ~{hit2, hit1, hit0};
  wire logic next_write_n = ~is_wr;
  // Unused lanes are masked so memory neither stores nor drives them
  wire logic [`EMSB_LANES-1:0] next_mask = (is_wr || is_rd) ? ~REQ.byte_en
                                                            : `EMSB_MASK_ALL;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DRAM_WRITE_STROBE_N <= 1'b1;
      DRAM_BYTE_LANE_MASK <= `EMSB_MASK_ALL;
      IO_BANK_SELECT_N <= `EMSB_SEL_IDLE;
    end else if (CLK_EN) begin
      DRAM_WRITE_STROBE_N <= next_write_n;
      DRAM_BYTE_LANE_MASK <= next_mask;
      IO_BANK_SELECT_N <= next_sel_n;
    end
  end

  property p_write_strobe;
    @(posedge CLOCK) disable iff (!RST_N)
      CLK_EN |=> (DRAM_WRITE_STROBE_N == ($past(REQ.op) != EMSB_OP_DRAM_WR));
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe wrong");

  property p_wr_mask;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_wr) |=> (DRAM_BYTE_LANE_MASK == ~$past(REQ.byte_en));
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write mask wrong");

  property p_rd_mask;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_rd) |=> (DRAM_BYTE_LANE_MASK == ~$past(REQ.byte_en));
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("read mask wrong");

  property p_idle_mask;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && !is_wr && !is_rd) |=> (DRAM_BYTE_LANE_MASK == `EMSB_MASK_ALL);
  endproperty
  a_idle_mask: assert property (p_idle_mask) else $error("idle lanes not masked");

  property p_bank0;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_io && bank_hit(REQ.addr, BANK0_BASE)) |=> (IO_BANK_SELECT_N == 3'h6);
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank 0 select wrong");

  property p_sel_low_io;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && !is_io) |=> (IO_BANK_SELECT_N == `EMSB_SEL_IDLE);
  endproperty
  a_sel_low_io: assert property (p_sel_low_io) else $error("select without I/O access");

  property p_bank2;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && hit2) |=> (IO_BANK_SELECT_N == 3'h3);
  endproperty
  a_bank2: assert property (p_bank2) else $error("bank 2 select wrong");

  property p_onehot;
    @(posedge CLOCK) disable iff (!RST_N)
      $countones(~IO_BANK_SELECT_N) <= 1;
  endproperty
  a_onehot: assert property (p_onehot) else $error("several selects low");

  property p_freeze;
    @(posedge CLOCK) disable iff (!RST_N)
      !CLK_EN |=> $stable(DRAM_WRITE_STROBE_N) && $stable(IO_BANK_SELECT_N);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");

  property p_freeze_mask;
    @(posedge CLOCK) disable iff (!RST_N)
      !CLK_EN
      |=> $stable(DRAM_BYTE_LANE_MASK);
  endproperty
  a_freeze_mask: assert property (p_freeze_mask)
    else $error("lane mask moved while disabled");

  property p_bank1;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && hit1)
      |=> (IO_BANK_SELECT_N == 3'h5);
  endproperty
  a_bank1: assert property (p_bank1)
    else $error("bank 1 select wrong");

  property p_bank0_only;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && hit0)
      |=> (IO_BANK_SELECT_N[2:1] == 2'h3);
  endproperty
  a_bank0_only: assert property (p_bank0_only)
    else $error("other select low in bank 0 window");

  property p_no_window;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_io && !hit0 && !hit1 && !hit2)
      |=> (IO_BANK_SELECT_N == `EMSB_SEL_IDLE);
  endproperty
  a_no_window: assert property (p_no_window)
    else $error("select low outside every window");

  property p_io_lanes_off;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_io)
      |=> (DRAM_BYTE_LANE_MASK == `EMSB_MASK_ALL);
  endproperty
  a_io_lanes_off: assert property (p_io_lanes_off)
    else $error("lanes unmasked during I/O access");

  property p_io_no_strobe;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_io)
      |=> DRAM_WRITE_STROBE_N;
  endproperty
  a_io_no_strobe: assert property (p_io_no_strobe)
    else $error("write strobe low during I/O access");

  property p_rd_strobe_high;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_rd)
      |=> DRAM_WRITE_STROBE_N;
  endproperty
  a_rd_strobe_high: assert property (p_rd_strobe_high)
    else $error("write strobe low during read");

  property p_dram_no_select;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && (is_wr || is_rd))
      |=> (IO_BANK_SELECT_N == `EMSB_SEL_IDLE);
  endproperty
  a_dram_no_select: assert property (p_dram_no_select)
    else $error("select low during memory access");

  // Cross-output checks: one op per cycle, so outputs of different kinds never overlap
  property p_strobe_sel_excl;
    @(posedge CLOCK) disable iff (!RST_N)
      !DRAM_WRITE_STROBE_N
      |-> (IO_BANK_SELECT_N == `EMSB_SEL_IDLE);
  endproperty
  a_strobe_sel_excl: assert property (p_strobe_sel_excl)
    else $error("select low with write strobe");

  property p_sel_mask_excl;
    @(posedge CLOCK) disable iff (!RST_N)
      (IO_BANK_SELECT_N != `EMSB_SEL_IDLE)
      |-> (DRAM_BYTE_LANE_MASK == `EMSB_MASK_ALL) && DRAM_WRITE_STROBE_N;
  endproperty
  a_sel_mask_excl: assert property (p_sel_mask_excl)
    else $error("memory lanes active with a select low");

  // Reset values are checked while reset is held, so no disable clause here
  property p_reset_select;
    @(posedge CLOCK)
      !RST_N
      |-> (IO_BANK_SELECT_N == `EMSB_SEL_IDLE);
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("select low in reset");

  property p_reset_strobe;
    @(posedge CLOCK)
      !RST_N
      |-> DRAM_WRITE_STROBE_N;
  endproperty
  a_reset_strobe: assert property (p_reset_strobe)
    else $error("write strobe low in reset");

  property p_reset_mask;
    @(posedge CLOCK)
      !RST_N
      |-> (DRAM_BYTE_LANE_MASK == `EMSB_MASK_ALL);
  endproperty
  a_reset_mask: assert property (p_reset_mask)
    else $error("lanes unmasked in reset");

  property p_wr_strobe_low;
    @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && is_wr)
      |=> !DRAM_WRITE_STROBE_N;
  endproperty
  a_wr_strobe_low: assert property (p_wr_strobe_low)
    else $error("write strobe high during write");
endmodule // emsb_strobe

/* File: inc/emsb_params.svh */
// Constants for the external memory strobe and I/O bank select block.
// Assumes a 32-bit data bus and byte-granular addresses from the core.
`ifndef EMSB_PARAMS_SVH
`define EMSB_PARAMS_SVH
`define EMSB_LANES 4
`define EMSB_BANKS 3
`define EMSB_ADDR_W 26
`define EMSB_BANK_SPAN_W 14
`define EMSB_BANK0_BASE 26'h3ff0000
`define EMSB_BANK1_BASE 26'h3ff4000
`define EMSB_BANK2_BASE 26'h3ff8000
`define EMSB_SEL_IDLE 3'h7
`define EMSB_MASK_ALL 4'hf
`endif

/* File: inc/emsb_pkg.sv */
// Types for the external memory strobe and I/O bank select block.
// Assumes emsb_params.svh is on the include path.
`include "emsb_params.svh"
package emsb_pkg;
  typedef enum logic [1:0] {
    EMSB_OP_NONE,
    EMSB_OP_DRAM_RD,
    EMSB_OP_DRAM_WR,
    EMSB_OP_IO
  } emsb_op_t;

  typedef struct packed {
    emsb_op_t op;
    logic [`EMSB_ADDR_W-1:0] addr;
    logic [`EMSB_LANES-1:0] byte_en;
  } emsb_req_t;

  typedef struct packed {
    logic write_n;
    logic [`EMSB_LANES-1:0] lane_mask;
    logic [`EMSB_BANKS-1:0] bank_sel_n;
  } emsb_pins_t;
endpackage

/* File: dv/emsb_mem_model.sv */
// Memory lane model on the far side of the strobe and lane mask pins.
// Assumes write data comes from the bench; masked lanes float, shown inverted.
`timescale 1ns/1ps
module emsb_mem_model (
  input wire logic clock,
  input wire logic write_n,
  input wire logic [3:0] mask,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem = 32'h0;
  logic [31:0] drv = 32'h0;
  assign rdata = drv;
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (!write_n && !mask[i]) mem[8*i+:8] <= wdata[8*i+:8];
      drv[8*i+:8] <= mask[i] ? ~drv[8*i+:8] : mem[8*i+:8];
    end
  end
endmodule // emsb_mem_model

/* File: dv/emsb_strobe_tb.sv */
// Self-checking bench for the strobe, lane mask and I/O bank select block.
// Assumes emsb_mem_model as the memory on the far side.
`timescale 1ns/1ps
`include "emsb_params.svh"
module emsb_strobe_tb;
  import emsb_pkg::*;
  logic clock = 0;
  logic rst_n = 1;
  logic clk_en = 1;
  emsb_req_t req = '0;
  logic [31:0] rdata;
  logic wr_n;
  logic [3:0] mask;
  logic [2:0] sel_n;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  emsb_strobe dut (.CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en), .REQ(req),
    .DRAM_WRITE_STROBE_N(wr_n), .DRAM_BYTE_LANE_MASK(mask), .IO_BANK_SELECT_N(sel_n));
  emsb_mem_model mem (.clock(clock), .write_n(wr_n), .mask(mask),
    .wdata(32'hddccbbaa), .rdata(rdata));
  initial forever #10 clock = ~clock;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(emsb_op_t op, logic [25:0] a, logic [3:0] be);
    req = '{op, a, be};
    @(posedge clock);
    #1;
  endtask
  task automatic t_dram;
    step(EMSB_OP_DRAM_WR, 0, 4'h3);
    chk("strobe", 0, wr_n);
    chk("mask", 32'hc, mask);
    step(EMSB_OP_DRAM_RD, 0, 4'hf);
    chk("strobe", 1, wr_n);
    step(EMSB_OP_NONE, 0, 4'h0);
    chk("rdata", 32'h0000bbaa, rdata);
    step(EMSB_OP_DRAM_RD, 0, 4'h1);
    chk("mask", 32'he, mask);
  endtask
  task automatic t_reset;
    step(EMSB_OP_DRAM_WR, 0, 4'h0);
    rst_n = 0;
    #1;
    chk("strobe", 1, wr_n);
    chk("mask", 32'hf, mask);
    chk("select", 7, sel_n);
    step(EMSB_OP_IO, `EMSB_BANK0_BASE, 4'hf);
    rst_n = 1;
    chk("select", 7, sel_n);
    step(EMSB_OP_IO, `EMSB_BANK0_BASE, 4'hf);
    chk("select", 6, sel_n);
  endtask
  task automatic t_io;
    logic [25:0] base [3] = '{`EMSB_BANK0_BASE, `EMSB_BANK1_BASE, `EMSB_BANK2_BASE};
    for (int k = 0; k < 3; k++) begin
      step(EMSB_OP_IO, base[k] + 26'h3fff, 4'hf);
      chk("select", ~(32'h1 << k) & 32'h7, sel_n);
    end
    step(EMSB_OP_IO, `EMSB_BANK2_BASE + 26'h4000, 4'hf);
    chk("select", 7, sel_n);
    step(EMSB_OP_IO, `EMSB_BANK1_BASE, 4'hf);
    clk_en = 0;
    step(EMSB_OP_DRAM_WR, 0, 4'h0);
    chk("select", 5, sel_n);
    chk("strobe", 1, wr_n);
    clk_en = 1;
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1 rst_n = 0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1;
    chk("select", 7, sel_n);
    t_dram();
    t_io();
    t_reset();
    report_and_stop();
  end
  always @(posedge clock) if (++cyc == 500) begin
    err_count++;
    report_and_stop();
  end
endmodule // emsb_strobe_tb
